// ===== core/urx_params.svh
// register map, bit positions, reset values and timing for the serial receiver
`ifndef URX_PARAMS_SVH
`define URX_PARAMS_SVH

`define URX_OFF_CTRL 32'h0000_0000
`define URX_OFF_DATA 32'h0000_0004
`define URX_OFF_BAUD 32'h0000_0008

`define URX_B_PORT_ENABLE 7
`define URX_B_NINE_BIT_ENABLE 6
`define URX_B_INTERRUPT_FLAG 5
`define URX_B_CONT_RECEIVE_ENABLE 4
`define URX_B_ADDR_DETECT_ENABLE 3
`define URX_B_FRAMING_ERROR_FLAG 2
`define URX_B_OVERRUN_ERROR_FLAG 1
`define URX_B_NINTH 0

`define URX_RST_CTRL_BIT 1'b0
`define URX_RST_LINE 1'b1

`define URX_CLK_HZ 100000000
`define URX_BIT_RATE 115200
`define URX_BAUD_DIV (`URX_CLK_HZ / `URX_BIT_RATE)

`define URX_LAST_BIT8 4'h7
`define URX_LAST_BIT9 4'h8

`define URX_RESP_OKAY 2'b00
`define URX_RESP_SLVERR 2'b10

`endif

// ===== core/urx_pkg.sv
// types shared by the serial receiver
package urx_pkg;

    typedef struct packed {
        logic frame_bad;
        logic bit9;
        logic [7:0] data;
    } urx_ent_t;

    typedef struct packed {
        logic receive_interrupt_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic received_ninth_bit;
    } urx_status_t;

    typedef enum logic [1:0] {
        URX_REG_CTRL,
        URX_REG_DATA,
        URX_REG_BAUD,
        URX_REG_NONE
    } urx_reg_t;

    typedef enum logic [1:0] {
        URX_RX_IDLE,
        URX_RX_START,
        URX_RX_DATA,
        URX_RX_STOP
    } urx_rx_state_t;

endpackage : urx_pkg

// ===== core/urx_core.sv
// serial receiver with two-entry fifo, error flags, address detect and axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "urx_params.svh"
// Function
// R1 - each fifo entry keeps its framing error
// R2 - missing stop bit flags framing error
// R3 - framing flag read-only, reception continues
// R4 - data read pops fifo, flag follows
// R5 - port enable low resets unit, clears flag
// R6 - receive enable low keeps framing flag
// R7 - framing error raises no interrupt alone
// R8 - all-bad fifo keeps flag set on reads
// R9 - fifo holds at most two characters
// R10 - third character into full fifo: overrun
// R11 - overrun keeps fifo readable, blocks new
// R12 - overrun cleared only by enable clear
// R13 - nine-bit mode shifts nine data bits
// R14 - ninth bit shows oldest unread character
// R15 - software reads flags before data byte
// R16 - address detect needs enable plus nine-bit
// R17 - address mode keeps only ninth-bit-set characters
// R18 - software clears address detect after match
// R19 - software re-arms address detect at end
// R20 - start low, lsb first, stop high
module urx_core #(
    parameter int ADDR_W = 4,
    parameter int FIFO_DEPTH = 2,
    parameter logic [15:0] BAUD_DIV_RST = 16'(`URX_BAUD_DIV)
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic rx_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output urx_pkg::urx_status_t rx_status_o
);
    import urx_pkg::*;
    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    function automatic urx_reg_t decode_reg(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        wide = 32'(a);
        if (wide == `URX_OFF_CTRL) begin
            return URX_REG_CTRL;
        end else if (wide == `URX_OFF_DATA) begin
            return URX_REG_DATA;
        end else if (wide == `URX_OFF_BAUD) begin
            return URX_REG_BAUD;
        end
        return URX_REG_NONE;
    endfunction : decode_reg
    // reset release and line synchroniser
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_prev_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= `URX_RST_LINE;
            rx_sync_q <= `URX_RST_LINE;
            rx_prev_q <= `URX_RST_LINE;
        end else begin
            rx_meta_q <= rx_i;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // control registers
    logic serial_port_enable_q;
    logic nine_bit_receive_enable_q;
    logic continuous_receive_enable_q;
    logic address_detect_enable_q;
    logic [15:0] baud_q;
    // write channel
    logic aw_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic w_hold_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_wr;
    urx_reg_t wr_sel;
    logic wr_ctrl;
    logic wr_baud_lo;
    logic wr_baud_hi;
    assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_o = !w_hold_q && !bvalid_q;
    assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_sel = decode_reg(awaddr_q);
    assign wr_ctrl = do_wr && wr_sel == URX_REG_CTRL && wstrb_q[0];
    assign wr_baud_lo = do_wr && wr_sel == URX_REG_BAUD && wstrb_q[0];
    assign wr_baud_hi = do_wr && wr_sel == URX_REG_BAUD && wstrb_q[1];
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
            w_hold_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end else if (do_wr) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end else if (do_wr) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `URX_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_sel == URX_REG_NONE) ? `URX_RESP_SLVERR : `URX_RESP_OKAY;
        end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end
    // flags other than the enables are status and ignore writes
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_port_enable_q <= `URX_RST_CTRL_BIT;
            nine_bit_receive_enable_q <= `URX_RST_CTRL_BIT;
            continuous_receive_enable_q <= `URX_RST_CTRL_BIT;
            address_detect_enable_q <= `URX_RST_CTRL_BIT;
        end else if (wr_ctrl) begin
            serial_port_enable_q <= wdata_q[`URX_B_PORT_ENABLE];
            nine_bit_receive_enable_q <= wdata_q[`URX_B_NINE_BIT_ENABLE];
            continuous_receive_enable_q <= wdata_q[`URX_B_CONT_RECEIVE_ENABLE];
            address_detect_enable_q <= wdata_q[`URX_B_ADDR_DETECT_ENABLE]; // R16 R18 R19
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            baud_q <= BAUD_DIV_RST;
        end else begin
            if (wr_baud_lo) begin
                baud_q[7:0] <= wdata_q[7:0];
            end
            if (wr_baud_hi) begin
                baud_q[15:8] <= wdata_q[15:8];
            end
        end
    end
    // receiver
    urx_rx_state_t state_q;
    logic [15:0] tick_cnt_q;
    logic [3:0] bit_cnt_q;
    logic [8:0] shift_q;
    logic nine_q;
    logic rx_run;
    logic tick;
    logic done;
    urx_ent_t new_ent;
    assign rx_run = serial_port_enable_q && continuous_receive_enable_q;
    assign tick = tick_cnt_q == 16'h0;
    assign done = state_q == URX_RX_STOP && tick;
    // eight-bit characters end up one place high in the shift register
    assign new_ent.data = nine_q ? shift_q[7:0] : shift_q[8:1]; // R13
    assign new_ent.bit9 = nine_q && shift_q[8]; // R14
    assign new_ent.frame_bad = !rx_sync_q; // R2
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= URX_RX_IDLE;
            tick_cnt_q <= 16'h0;
            bit_cnt_q <= 4'h0;
            shift_q <= 9'h0;
            nine_q <= 1'b0;
        end else if (!rx_run) begin
            state_q <= URX_RX_IDLE; // R5
        end else begin
            unique case (state_q)
                URX_RX_IDLE: begin
                    // edge, not level, so a held-low line does not retrigger
                    if (rx_prev_q && !rx_sync_q) begin
                        state_q <= URX_RX_START; // R20
                        tick_cnt_q <= baud_q >> 1;
                        nine_q <= nine_bit_receive_enable_q;
                    end
                end
                URX_RX_START: begin
                    if (!tick) begin
                        tick_cnt_q <= tick_cnt_q - 16'h1;
                    end else if (!rx_sync_q) begin
                        state_q <= URX_RX_DATA;
                        tick_cnt_q <= baud_q - 16'h1;
                        bit_cnt_q <= 4'h0;
                    end else begin
                        state_q <= URX_RX_IDLE;
                    end
                end
                URX_RX_DATA: begin
                    if (!tick) begin
                        tick_cnt_q <= tick_cnt_q - 16'h1;
                    end else begin
                        shift_q <= {rx_sync_q, shift_q[8:1]}; // R20
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        tick_cnt_q <= baud_q - 16'h1;
                        if (bit_cnt_q == (nine_q ? `URX_LAST_BIT9 : `URX_LAST_BIT8)) begin
                            state_q <= URX_RX_STOP; // R13
                        end
                    end
                end
                URX_RX_STOP: begin
                    if (!tick) begin
                        tick_cnt_q <= tick_cnt_q - 16'h1;
                    end else begin
                        state_q <= URX_RX_IDLE; // R3
                    end
                end
            endcase
        end
    end
    // fifo
    urx_ent_t fifo_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic overrun_error_flag_q;
    logic empty;
    logic full;
    logic keep;
    logic push;
    logic pop;
    logic ovr_set;
    urx_ent_t head;
    // address filter only works with nine-bit characters
    assign keep = !(address_detect_enable_q && nine_q && !new_ent.bit9); // R17
    assign empty = count_q == '0;
    assign full = count_q == CNT_W'(FIFO_DEPTH); // R9
    assign push = done && keep && !overrun_error_flag_q && (!full || pop); // R11
    assign ovr_set = done && keep && !overrun_error_flag_q && full && !pop; // R10
    assign head = fifo_q[rd_ptr_q];
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            fifo_q[wr_ptr_q] <= new_ent; // R1
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (!serial_port_enable_q) begin
            wr_ptr_q <= '0; // R5
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1); // R4
            end
            if (push && !pop) begin
                count_q <= count_q + CNT_W'(1);
            end else if (pop && !push) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end
    // the set wins over the clear: the receiver is forced idle only one cycle after either enable goes low
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            overrun_error_flag_q <= 1'b0;
        end else if (ovr_set) begin
            overrun_error_flag_q <= 1'b1; // R10
        end else if (!rx_run) begin
            overrun_error_flag_q <= 1'b0; // R12
        end
    end
    // status seen by software; a framing error never raises the interrupt flag on its own
    assign rx_status_o.receive_interrupt_flag = !empty; // R7 R17
    assign rx_status_o.framing_error_flag = !empty && head.frame_bad; // R1 R6 R8
    assign rx_status_o.overrun_error_flag = overrun_error_flag_q;
    assign rx_status_o.received_ninth_bit = !empty && head.bit9; // R14
    // read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_fire;
    urx_reg_t rd_sel;
    logic [31:0] ctrl_word;
    logic [31:0] rd_word;

    assign s_axi_arready_o = !rvalid_q;
    assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
    assign rd_sel = decode_reg(s_axi_araddr_i);
    // only a data read advances the fifo; status reads are free of side effects
    assign pop = ar_fire && rd_sel == URX_REG_DATA && !empty; // R4 R15

    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[`URX_B_PORT_ENABLE] = serial_port_enable_q;
        ctrl_word[`URX_B_NINE_BIT_ENABLE] = nine_bit_receive_enable_q;
        ctrl_word[`URX_B_INTERRUPT_FLAG] = rx_status_o.receive_interrupt_flag;
        ctrl_word[`URX_B_CONT_RECEIVE_ENABLE] = continuous_receive_enable_q;
        ctrl_word[`URX_B_ADDR_DETECT_ENABLE] = address_detect_enable_q;
        ctrl_word[`URX_B_FRAMING_ERROR_FLAG] = rx_status_o.framing_error_flag; // R3
        ctrl_word[`URX_B_OVERRUN_ERROR_FLAG] = rx_status_o.overrun_error_flag;
        ctrl_word[`URX_B_NINTH] = rx_status_o.received_ninth_bit;
    end

    assign rd_word = (rd_sel == URX_REG_CTRL) ? ctrl_word :
                     (rd_sel == URX_REG_DATA) ? {24'h0, empty ? 8'h0 : head.data} :
                     (rd_sel == URX_REG_BAUD) ? {16'h0, baud_q} : 32'h0;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `URX_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= (rd_sel == URX_REG_NONE) ? `URX_RESP_SLVERR : `URX_RESP_OKAY;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;

endmodule : urx_core

// ===== test/urx_core_chk.sv
// port-level assertions for the serial receiver
`timescale 1ns/1ps
module urx_core_chk (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire urx_pkg::urx_status_t rx_status_o
);
    import urx_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_both_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_resp_next;
        !s_axi_bvalid_o ##1 s_axi_bvalid_o;
    endsequence
    property p_wr_resp; s_both_taken |=> s_resp_next; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response timing wrong");
    property p_b_hold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_rd_resp; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer not held");
    property p_frame_head;
        rx_status_o.framing_error_flag |-> rx_status_o.receive_interrupt_flag;
    endproperty
    a_frame_head: assert property (p_frame_head) else $error("framing flag with empty fifo");
    property p_ninth_head;
        rx_status_o.received_ninth_bit |-> rx_status_o.receive_interrupt_flag;
    endproperty
    a_ninth_head: assert property (p_ninth_head) else $error("ninth bit with empty fifo");
    // framing flag only rises with a new head: a push into empty or a pop
    property p_frame_step;
        $rose(rx_status_o.framing_error_flag) |->
            $rose(rx_status_o.receive_interrupt_flag) || $rose(s_axi_rvalid_o);
    endproperty
    a_frame_step: assert property (p_frame_step) else $error("framing flag rose alone");
    property p_ovr_full;
        $rose(rx_status_o.overrun_error_flag) |-> $past(rx_status_o.receive_interrupt_flag);
    endproperty
    a_ovr_full: assert property (p_ovr_full) else $error("overrun with empty fifo");
    property p_ovr_keep;
        rx_status_o.overrun_error_flag && !s_axi_bvalid_o |=> rx_status_o.overrun_error_flag;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun cleared without write");
    property p_ovr_block;
        rx_status_o.overrun_error_flag |=> !$rose(rx_status_o.receive_interrupt_flag);
    endproperty
    a_ovr_block: assert property (p_ovr_block) else $error("char taken during overrun");
endmodule : urx_core_chk

bind urx_core urx_core_chk chk_inst (
    .core_clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .rx_status_o
);

// ===== test/urx_tx_model.sv
// remote transmitter driving the serial line
`timescale 1ns/1ps
module urx_tx_model #(
    parameter int BIT_CLKS = 8
) (
    input wire logic core_clk_i,
    output logic line_o
);
    // line idles high, as with a pull-up, so no stale level between frames
    initial line_o = 1'b1;
    task automatic send(input logic [8:0] chr, input logic nine, input logic stop_ok);
        logic [10:0] frame;
        frame = nine ? {stop_ok, chr, 1'b0} : {1'b1, stop_ok, chr[7:0], 1'b0};
        // one trailing idle bit, two for eight-bit characters, so a bad stop never runs into the next start
        for (int i = 0; i < 12; i++) begin
            repeat (BIT_CLKS) begin
                @(posedge core_clk_i);
                line_o <= (i < 11) ? frame[i] : 1'b1;
            end
        end
    endtask : send
endmodule : urx_tx_model

// ===== test/tb.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ps
`include "urx_params.svh"
module tb;
    import urx_pkg::*;
    localparam int BIT_CLKS = 8;
    localparam logic [3:0] A_CTL = 4'(`URX_OFF_CTRL);
    localparam logic [3:0] A_DAT = 4'(`URX_OFF_DATA);
    localparam logic [3:0] A_BAUD = 4'(`URX_OFF_BAUD);
    typedef struct packed {
        logic [7:0] ctl;
        logic [8:0] chr;
        logic stop_ok;
        logic [3:0] st;
        logic [7:0] dat;
    } urx_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic line;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    urx_status_t st;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    // ctrl, char, stop good, status {intr,framing,overrun,ninth}, data byte
    urx_row_t rows [9] = '{
        '{8'h90, 9'h055, 1'b1, 4'h8, 8'h55},
        '{8'h90, 9'h0a3, 1'b0, 4'hc, 8'ha3},
        '{8'hd0, 9'h1c4, 1'b1, 4'h9, 8'hc4},
        '{8'hd0, 9'h0c4, 1'b1, 4'h8, 8'hc4},
        '{8'hd8, 9'h03c, 1'b1, 4'h0, 8'h00},
        '{8'hd8, 9'h13c, 1'b1, 4'h9, 8'h3c},
        '{8'hd0, 9'h012, 1'b1, 4'h8, 8'h12},
        '{8'hd8, 9'h034, 1'b1, 4'h0, 8'h00},
        '{8'h98, 9'h03c, 1'b1, 4'h8, 8'h3c}
    };
    urx_core #(.BAUD_DIV_RST(16'(BIT_CLKS))) urx_core_inst (
        .core_clk_i(clk), .arst_n_i(rst_n), .rx_i(line),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_status_o(st)
    );
    urx_tx_model #(.BIT_CLKS(BIT_CLKS)) urx_tx_model_inst (
        .core_clk_i(clk),
        .line_o(line)
    );
    always #5 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk_val
    // status is sampled at the falling edge, well clear of the updates
    task automatic chk_st(input string what, input logic [3:0] e);
        @(negedge clk);
        chk_val(what, {28'h0, e}, {28'h0, st});
    endtask : chk_st
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic set_ctl(input logic [7:0] c);
        wr(A_CTL, {24'h0, c});
        chk_val("ctrl write resp", 32'(`URX_RESP_OKAY), {30'h0, r});
    endtask : set_ctl
    task automatic rdd(input logic [7:0] e);
        rd(A_DAT);
        chk_val("data read", {24'h0, e}, d);
    endtask : rdd
    task automatic tx8(input logic [7:0] c, input logic ok);
        urx_tx_model_inst.send({1'b0, c}, 1'b0, ok);
    endtask : tx8
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_st("status after reset", 4'h0);
        rd(A_CTL);
        chk_val("ctrl after reset", 32'h0, d);
        rd(A_BAUD);
        chk_val("baud after reset", 32'(BIT_CLKS), d);
        rd(4'hc);
        chk_val("unmapped read resp", 32'(`URX_RESP_SLVERR), {30'h0, r});
        chk_val("unmapped read data", 32'h0, d);
        wr(4'hc, 32'h0);
        chk_val("unmapped write resp", 32'(`URX_RESP_SLVERR), {30'h0, r});
        // receiver is off here, so a foreign bit rate is harmless until restored
        wr(A_BAUD, 32'hffff_0a5c);
        chk_val("baud write resp", 32'(`URX_RESP_OKAY), {30'h0, r});
        rd(A_BAUD);
        chk_val("baud write", 32'h0000_0a5c, d);
        wr(A_BAUD, 32'(BIT_CLKS));
        rd(A_BAUD);
        chk_val("baud restored", 32'(BIT_CLKS), d);
        foreach (rows[i]) begin
            set_ctl(rows[i].ctl);
            urx_tx_model_inst.send(rows[i].chr, rows[i].ctl[6], rows[i].stop_ok);
            chk_st("status", rows[i].st);
            rd(A_CTL);
            chk_val("ctrl read", {24'h0, rows[i].ctl[7:6], rows[i].st[3], rows[i].ctl[4:3],
                rows[i].st[2:0]}, d);
            rdd(rows[i].dat);
            chk_st("status after pop", 4'h0);
        end
        set_ctl(8'h90);
        tx8(8'h11, 1'b1);
        tx8(8'h22, 1'b0);
        tx8(8'h33, 1'b1);
        chk_st("third char overruns", 4'ha);
        tx8(8'h44, 1'b1);
        rdd(8'h11);
        chk_st("bad head after pop", 4'he);
        rdd(8'h22);
        tx8(8'h55, 1'b1);
        chk_st("blocked while overrun", 4'h2);
        set_ctl(8'h80);
        chk_st("overrun cleared", 4'h0);
        set_ctl(8'h90);
        tx8(8'h66, 1'b1);
        rdd(8'h66);
        tx8(8'h77, 1'b0);
        tx8(8'h88, 1'b0);
        rdd(8'h77);
        chk_st("bad after bad", 4'hc);
        set_ctl(8'h80);
        chk_st("receive off keeps flag", 4'hc);
        set_ctl(8'h07);
        chk_st("port off clears", 4'h0);
        rd(A_CTL);
        chk_val("read-only bits", 32'h0, d);
        rdd(8'h00);
        tally_and_finish();
    end
endmodule : tb
